// *** bench/reflex_bank_tb_top.sv ***
// Purpose: Self-checking bench for the reflex function block bank.
// Assumes: Millisecond and holdoff counts shortened to 4 and 20.
// Notes: Delta 0 makes every compare a pure function of the word.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
   n_tests++; \
   if ((gt) !== (ex)) begin \
      num_errors++; \
      $display("BAD %s exp %h got %h", nm, ex, gt); \
   end \
end

module reflex_bank_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, cos_strobe, e, a0;
   logic [7:0] cos_bits, bits;
   logic [15:0] cos_word, th1, th2, cw;
   logic [1:0] out_ch;
   logic [1:0] cs [7] = '{2'h1, 2'h3, 2'h1, 2'h3, 2'h0, 2'h1, 2'h3};
   logic [15:0] hw [4] = '{16'h0032, 16'h0069, 16'h006E, 16'h0069};
   int num_errors = 0;
   int n_tests = 0;
   int i, k, m, cnt;

   always #10 pclk = ~pclk;

   reflex_bank #(.MS_CYCLES(4), .HOLDOFF_CYCLES(20)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cos_strobe(cos_strobe),
      .cos_bits(cos_bits), .cos_word(cos_word), .out_ch(out_ch));

   reflex_src src (.pclk(pclk), .cos_strobe(cos_strobe),
      .cos_bits(cos_bits), .cos_word(cos_word));

   // ----------------------------------------
   // Bus tasks and expectations
   // ----------------------------------------
   task automatic end_sim();
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         `CHK("pready", 1'b1, pready)
         end_sim();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   function automatic int sx(logic sg, logic [15:0] v);
      return sg ? {{16{v[15]}}, v} : {16'h0000, v};
   endfunction

   // XOR inputs are never inverted; disabled output is 0 after inversion
   function automatic logic bexp(logic [7:0] b, int md, logic [2:0] ii,
                                 logic io);
      logic [2:0] v;
      logic r;
      v = b[3:1] ^ ii;
      r = (md == 0) ? b[1] ^ b[2] : (md == 1) ? v[0] & v[1] : &v;
      return b[0] & (r ^ io);
   endfunction

   function automatic logic cexp(logic sg, int md, logic [15:0] w,
                                 logic [15:0] p, logic [15:0] q);
      int x, a, b;
      x = sx(sg, w);
      a = sx(sg, p);
      b = sx(sg, q);
      case (md)
         0: return x < a;
         1: return x > a;
         2: return x >= a && x <= b;
         default: return x < a || x > b;
      endcase
   endfunction

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      k = $urandom(32'hdd67_2c09);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0000_0000);
      `CHK("ctrl", 32'h0000_0000, rd)
      apb(1'b0, 8'h80, 32'h0000_0000);
      `CHK("unmapped", 1'b1, er)
      for (i = 0; i < 12; i++) begin
         m = (i < 3) ? i : $urandom_range(2);
         k = $urandom_range(15);
         bits = 8'($urandom);
         wr(8'h20, {23'h0, k[2:0], k[3], m[1:0], 3'h1});
         src.push(bits, 16'h0000, 30);
         `CHK("bool", bexp(bits, m, k[2:0], k[3]), out_ch[0])
      end
      for (i = 0; i < 16; i++) begin
         e = i[3];
         th1 = 16'($urandom);
         th2 = 16'($urandom);
         if (sx(e, th1) > sx(e, th2)) begin
            cw = th1;
            th1 = th2;
            th2 = cw;
         end
         cw = (i % 3 == 0) ? th2 : 16'($urandom);
         wr(8'h20, {27'h0, i[1:0], 2'h1, ~e});
         wr(8'h24, {16'h0000, th1});
         wr(8'h28, {16'h0000, th2});
         src.push(8'h01, cw, 30);
         `CHK("cmp", cexp(e, i % 4, cw, th1, th2), out_ch[0])
      end
      wr(8'h20, 32'h0000_0003);
      wr(8'h24, 32'h0000_0064);
      wr(8'h2C, 32'h0000_000A);
      for (i = 0; i < 4; i++) begin
         src.push(8'h01, hw[i], 30);
         `CHK("hyst", i < 2, out_ch[0])
      end
      wr(8'h00, 32'h0000_0005);
      wr(8'h40, 32'h0000_0003);
      wr(8'h44, 32'h0000_0005);
      // Counter input level carries over from one pass to the next
      a0 = 1'b0;
      for (k = 0; k < 2; k++) begin
         wr(8'h20, k ? 32'h0000_020C : 32'h0000_0004);
         wr(8'h30, k ? 32'h0000_0000 : 32'h0000_FFFE);
         cnt = k ? 0 : 65534;
         for (i = 0; i < 7; i++) begin
            bits = {6'h00, cs[i]};
            if (bits[0] && bits[1] != a0 && bits[1] != k[0]) begin
               cnt = k ? cnt - 1 : cnt + 1;
            end
            a0 = bits[1];
            src.push(bits, 16'($urandom), 30);
         end
         apb(1'b0, 8'h34, 32'h0000_0000);
         `CHK("count", {16'h0000, cnt[15:0]}, rd)
         `CHK("chain", {cnt[15:0] < 16'h0005, 1'b0}, out_ch)
      end
      apb(1'b0, 8'h04, 32'h0000_0000);
      `CHK("status", 8'h88, rd[7:0])
      wr(8'h00, 32'h0000_0000);
      wr(8'h20, 32'h0000_0015);
      wr(8'h30, 32'h0000_0003);
      src.push(8'h01, 16'h0000, 30);
      src.push(8'h03, 16'h0000, 4);
      `CHK("tmr run", 1'b1, out_ch[0])
      repeat (30) @(posedge pclk);
      `CHK("tmr done", 1'b0, out_ch[0])
      apb(1'b0, 8'h34, 32'h0000_0000);
      `CHK("tmr hold", 32'h0000_0003, rd)
      src.push(8'h07, 16'h0000, 30);
      apb(1'b0, 8'h34, 32'h0000_0000);
      `CHK("tmr clr", 32'h0000_0000, rd)
      wr(8'h20, 32'h0000_0001);
      src.push(8'h03, 16'h0000, 5);
      src.push(8'h07, 16'h0000, 30);
      `CHK("holdoff", 1'b1, out_ch[0])
      src.push(8'h07, 16'h0000, 30);
      `CHK("xor", 1'b0, out_ch[0])
      wr(8'h00, 32'h0000_0004);
      wr(8'h40, 32'h0000_0002);
      src.push(8'h07, 16'h8000, 30);
      `CHK("slt", 2'h2, out_ch)
      end_sim();
   end
endmodule

// *** bench/reflex_src.sv ***
// Purpose: Island sources that send input updates to the bank.
// Assumes: pclk from the bench; the caller spaces the updates.
// Notes: Released lines show inverted data, so a late sample is caught.
`timescale 1ns/1ps

module reflex_src (
   input wire logic pclk,
   output logic cos_strobe,
   output logic [7:0] cos_bits,
   output logic [15:0] cos_word
);
   initial begin
      cos_strobe = 1'b0;
      cos_bits = 8'h00;
      cos_word = 16'h0000;
   end

   // Strobe stands three edges; its sync needs at least two
   task automatic push(input logic [7:0] b, input logic [15:0] w,
                       input int gap);
      @(posedge pclk);
      cos_strobe <= 1'b1;
      cos_bits <= b;
      cos_word <= w;
      repeat (3) @(posedge pclk);
      cos_strobe <= 1'b0;
      cos_bits <= ~b;
      cos_word <= ~w;
      repeat (gap) @(posedge pclk);
   endtask
endmodule

// *** src/reflex_bank.sv ***
// Purpose: Two-slot reflex function block bank with APB configuration.
// Assumes: cos_strobe is held high at least two pclk cycles per update.
// Notes: Slot 0 result can be chained into slot 1 through a buffer.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps

module reflex_bank #(
   parameter int MS_CYCLES = reflex_pkg::MS_CYCLES_DFLT,
   parameter int HOLDOFF_CYCLES = reflex_pkg::HOLDOFF_CYCLES_DFLT
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cos_strobe,
   input wire logic [7:0] cos_bits,
   input wire logic [15:0] cos_word,
   output logic [1:0] out_ch
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic chain;
      logic [1:0] always_en;
      logic [1:0][15:0] cfg;
      logic [1:0][15:0] thr1;
      logic [1:0][15:0] thr2;
      logic [1:0][15:0] delta;
      logic [1:0][15:0] preset;
      logic [1:0][15:0] acc;
      logic [1:0] cmp;
      reflex_pkg::tmr_state_t [1:0] tst;
      logic [1:0][9:0] unit_cnt;
      logic [19:0] ms_cnt;
      logic [19:0] holdoff;
      logic cos_s1;
      logic cos_s2;
      logic cos_s3;
      logic [7:0] bits_s1;
      logic [7:0] bits_s2;
      logic [15:0] word_s1;
      logic [15:0] word_s2;
      logic [7:0] img_bits;
      logic [7:0] img_prev;
      logic [15:0] img_word;
      logic [15:0] chain_buf;
      logic chain_prev;
      logic [1:0] out_ch;
   } state_t;

   state_t q;
   state_t next_q;
   logic [1:0] en_w;
   logic [1:0] out_w;
   logic [1:0] rise_w;
   logic [1:0] fall_w;
   logic [1:0][2:0] kind_w;
   logic ms_tick;
   logic accept;
   logic wr;

   function automatic logic signed [17:0] ext(input logic [15:0] v,
                                               input logic sgn);
      ext = sgn ? {{2{v[15]}}, v} : {2'b00, v};
   endfunction

   function automatic logic [9:0] unit_div(input logic [1:0] u);
      case (u)
         2'h0: unit_div = reflex_pkg::UNIT_DIV_1;
         2'h1: unit_div = reflex_pkg::UNIT_DIV_10;
         2'h2: unit_div = reflex_pkg::UNIT_DIV_100;
         default: unit_div = reflex_pkg::UNIT_DIV_1000;
      endcase
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [1:0] mode;
      logic [2:0] inv;
      logic a, b, c, a_prev, f, tedge, sgn, hit, rs, used_slot;
      logic signed [17:0] x, t1, t2, d;
      logic [9:0] div;
      logic [4:0] off;
      logic [3:0] used;
      mode = '0;
      inv = '0;
      a = 1'b0;
      b = 1'b0;
      c = 1'b0;
      a_prev = 1'b0;
      f = 1'b0;
      tedge = 1'b0;
      sgn = 1'b0;
      hit = 1'b0;
      x = '0;
      t1 = '0;
      t2 = '0;
      d = '0;
      div = '0;
      used = '0;
      off = paddr[4:0];
      rs = (paddr[7:5] == reflex_pkg::SLOT_PAGE1);
      used_slot = (paddr[7:5] == reflex_pkg::SLOT_PAGE0) || rs;
      next_q = q;
      en_w = '0;
      out_w = '0;
      rise_w = '0;
      fall_w = '0;
      for (int s = 0; s < 2; s++) begin
         kind_w[s] = q.cfg[s][reflex_pkg::KIND_LSB +: 3];
         if (kind_w[s] != reflex_pkg::KIND_OFF) begin
            used = used + 4'h1;
         end
      end

      // Input synchronisers and image update with holdoff
      next_q.cos_s1 = cos_strobe;
      next_q.cos_s2 = q.cos_s1;
      next_q.cos_s3 = q.cos_s2;
      next_q.bits_s1 = cos_bits;
      next_q.bits_s2 = q.bits_s1;
      next_q.word_s1 = cos_word;
      next_q.word_s2 = q.word_s1;
      next_q.img_prev = q.img_bits;
      next_q.chain_prev = q.chain_buf[0];
      accept = q.cos_s2 && !q.cos_s3 && (q.holdoff == '0);
      if (accept) begin
         next_q.img_bits = q.bits_s2;
         next_q.img_word = q.word_s2;
         next_q.holdoff = 20'(HOLDOFF_CYCLES - 1);
      end else if (q.holdoff != '0) begin
         next_q.holdoff = q.holdoff - 20'h0_0001;
      end

      // Shared millisecond time base
      ms_tick = (q.ms_cnt == 20'(MS_CYCLES - 1));
      next_q.ms_cnt = ms_tick ? '0 : q.ms_cnt + 20'h0_0001;

      // APB: answer in the first access cycle
      next_q.pready = psel && !penable;
      next_q.pslverr = 1'b0;
      next_q.prdata = '0;
      if (psel && !penable) begin
         if (paddr == reflex_pkg::ADDR_CTRL) begin
            next_q.prdata[reflex_pkg::CHAIN_BIT] = q.chain;
            next_q.prdata[reflex_pkg::ALWAYS_EN_LSB +: 2] = q.always_en;
         end else if (paddr == reflex_pkg::ADDR_STATUS) begin
            next_q.prdata[1:0] = q.out_ch;
            next_q.prdata[reflex_pkg::ST_USED_LSB +: 4] = used;
            next_q.prdata[reflex_pkg::ST_BUSY_BIT] = (q.holdoff != '0);
            next_q.prdata[reflex_pkg::ST_CHAIN_BIT] = q.chain;
         end else if (used_slot) begin
            case (off)
               reflex_pkg::OFS_CFG: next_q.prdata[15:0] = q.cfg[rs];
               reflex_pkg::OFS_THR1: next_q.prdata[15:0] = q.thr1[rs];
               reflex_pkg::OFS_THR2: next_q.prdata[15:0] = q.thr2[rs];
               reflex_pkg::OFS_DELTA: next_q.prdata[15:0] = q.delta[rs];
               reflex_pkg::OFS_PRESET: next_q.prdata[15:0] = q.preset[rs];
               reflex_pkg::OFS_ACC: next_q.prdata[15:0] = q.acc[rs];
               default: next_q.pslverr = 1'b1;
            endcase
         end else begin
            next_q.pslverr = 1'b1;
         end
      end
      wr = psel && penable && q.pready && pwrite && !q.pslverr;

      // Two slots; slot 1 may take slot 0 through the buffer
      for (int s = 0; s < 2; s++) begin
         mode = q.cfg[s][reflex_pkg::MODE_LSB +: 2];
         inv = q.cfg[s][reflex_pkg::INV_IN_LSB +: 3];
         en_w[s] = q.always_en[s] | q.img_bits[4*s];
         a = q.img_bits[4*s+1];
         a_prev = q.img_prev[4*s+1];
         b = q.img_bits[4*s+2];
         c = q.img_bits[4*s+3];
         x = ext(q.img_word, 1'b0);
         sgn = (kind_w[s] == reflex_pkg::KIND_SCMP);
         if (s == 1 && q.chain) begin
            a = q.chain_buf[0];
            a_prev = q.chain_prev;
         end
         x = ext((s == 1 && q.chain) ? q.chain_buf : q.img_word, sgn);
         t1 = ext(q.thr1[s], sgn);
         t2 = ext(q.thr2[s], sgn);
         d = ext(q.delta[s], 1'b0);
         rise_w[s] = a && !a_prev;
         fall_w[s] = !a && a_prev;
         f = 1'b0;
         case (kind_w[s])
            reflex_pkg::KIND_BOOL: begin
               case (mode)
                  reflex_pkg::BOOL_XOR: f = a ^ b;
                  reflex_pkg::BOOL_AND2: f = (a ^ inv[0]) & (b ^ inv[1]);
                  reflex_pkg::BOOL_AND3: begin
                     f = (a ^ inv[0]) & (b ^ inv[1]) & (c ^ inv[2]);
                  end
                  default: f = 1'b0;
               endcase
            end
            reflex_pkg::KIND_SCMP, reflex_pkg::KIND_UCMP: begin
               if (en_w[s]) begin
                  case (mode)
                     reflex_pkg::CMP_LT: begin
                        if (x < t1) begin
                           next_q.cmp[s] = 1'b1;
                        end else if (x >= t1 + d) begin
                           next_q.cmp[s] = 1'b0;
                        end
                     end
                     reflex_pkg::CMP_GT: begin
                        if (x > t1) begin
                           next_q.cmp[s] = 1'b1;
                        end else if (x <= t1 - d) begin
                           next_q.cmp[s] = 1'b0;
                        end
                     end
                     reflex_pkg::CMP_IN: begin
                        if (x >= t1 && x <= t2) begin
                           next_q.cmp[s] = 1'b1;
                        end else if (x < t1 - d || x > t2 + d) begin
                           next_q.cmp[s] = 1'b0;
                        end
                     end
                     default: begin
                        if (x < t1 || x > t2) begin
                           next_q.cmp[s] = 1'b1;
                        end else if (x >= t1 + d && x <= t2 - d) begin
                           next_q.cmp[s] = 1'b0;
                        end
                     end
                  endcase
               end
               f = q.cmp[s];
            end
            reflex_pkg::KIND_CNT: begin
               hit = mode[0] ? fall_w[s] : rise_w[s];
               if (en_w[s] && hit) begin
                  if (q.cfg[s][reflex_pkg::DOWN_BIT]) begin
                     next_q.acc[s] = q.acc[s] - 16'h0001;
                  end else begin
                     next_q.acc[s] = q.acc[s] + 16'h0001;
                  end
               end
            end
            reflex_pkg::KIND_TMR: begin
               div = unit_div(q.cfg[s][reflex_pkg::UNIT_LSB +: 2]);
               tedge = (mode == reflex_pkg::TMR_DSTART ||
                        mode == reflex_pkg::TMR_RISE) ? rise_w[s] : fall_w[s];
               if (b) begin
                  next_q.acc[s] = '0;
                  next_q.unit_cnt[s] = '0;
                  next_q.tst[s] = reflex_pkg::TMR_IDLE;
               end else if (en_w[s]) begin
                  if (tedge) begin
                     next_q.acc[s] = '0;
                     next_q.unit_cnt[s] = '0;
                     next_q.tst[s] = (q.preset[s] == '0) ?
                        reflex_pkg::TMR_DONE : reflex_pkg::TMR_RUN;
                  end else if (q.tst[s] == reflex_pkg::TMR_RUN && ms_tick) begin
                     if (q.unit_cnt[s] == div - 10'h001) begin
                        next_q.unit_cnt[s] = '0;
                        next_q.acc[s] = q.acc[s] + 16'h0001;
                        if (q.acc[s] + 16'h0001 == q.preset[s]) begin
                           next_q.tst[s] = reflex_pkg::TMR_DONE;
                        end
                     end else begin
                        next_q.unit_cnt[s] = q.unit_cnt[s] + 10'h001;
                     end
                  end
               end
               case (mode)
                  reflex_pkg::TMR_DSTART: begin
                     f = (q.tst[s] == reflex_pkg::TMR_DONE) && a;
                  end
                  reflex_pkg::TMR_DSTOP: begin
                     f = a || (q.tst[s] == reflex_pkg::TMR_RUN);
                  end
                  default: f = (q.tst[s] == reflex_pkg::TMR_RUN);
               endcase
            end
            default: f = 1'b0;
         endcase
         out_w[s] = en_w[s] && (kind_w[s] != reflex_pkg::KIND_OFF) &&
                    (f ^ q.cfg[s][reflex_pkg::INV_OUT_BIT]);
      end

      // Buffer carries the slot 0 count word, or the one-bit slot 0 result for any other kind
      if (kind_w[0] == reflex_pkg::KIND_CNT) begin
         next_q.chain_buf = q.acc[0];
      end else begin
         next_q.chain_buf = {15'h0000, out_w[0]};
      end
      // Slot 0 stays off its channel when it feeds slot 1
      next_q.out_ch[0] = out_w[0] && !q.chain &&
                         (kind_w[0] != reflex_pkg::KIND_CNT);
      next_q.out_ch[1] = out_w[1] &&
                         (kind_w[1] != reflex_pkg::KIND_CNT);

      // Register writes win over the block updates above
      if (wr) begin
         if (paddr == reflex_pkg::ADDR_CTRL) begin
            next_q.chain = pwdata[reflex_pkg::CHAIN_BIT];
            next_q.always_en = pwdata[reflex_pkg::ALWAYS_EN_LSB +: 2];
         end else if (used_slot) begin
            case (off)
               reflex_pkg::OFS_CFG: next_q.cfg[rs] = pwdata[15:0];
               reflex_pkg::OFS_THR1: next_q.thr1[rs] = pwdata[15:0];
               reflex_pkg::OFS_THR2: next_q.thr2[rs] = pwdata[15:0];
               reflex_pkg::OFS_DELTA: next_q.delta[rs] = pwdata[15:0];
               reflex_pkg::OFS_PRESET: begin
                  next_q.preset[rs] = pwdata[15:0];
                  if (kind_w[rs] == reflex_pkg::KIND_CNT) begin
                     next_q.acc[rs] = pwdata[15:0];
                  end
               end
               default: next_q.prdata = next_q.prdata;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.tst <= {2{reflex_pkg::TMR_IDLE}};
      end else begin
         q <= next_q;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign out_ch = q.out_ch;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence trig_rise0;
      kind_w[0] == reflex_pkg::KIND_TMR && q.cfg[0][4] && !q.cfg[0][3] &&
      en_w[0] && !q.img_bits[2] && rise_w[0] && q.preset[0] != '0 && !wr;
   endsequence

   apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("apb answer not one cycle");
   holdoff_load_a: assert property (accept |=>
      q.holdoff == 20'(HOLDOFF_CYCLES - 1))
      else $error("holdoff not loaded");
   holdoff_gate_a: assert property ($changed(q.img_bits) |->
      $past(q.holdoff) == '0)
      else $error("input update taken during holdoff");
   chain_quiet_a: assert property (q.chain ##1 q.chain |->
      !q.out_ch[0])
      else $error("chained slot 0 drove channel");
   count_up_a: assert property (kind_w[0] == reflex_pkg::KIND_CNT &&
      en_w[0] && rise_w[0] && !q.cfg[0][3] && !q.cfg[0][9] && !wr
      |=> q.acc[0] == $past(q.acc[0]) + 16'h0001)
      else $error("counter missed rising edge");
   count_freeze_a: assert property (kind_w[0] == reflex_pkg::KIND_CNT &&
      !en_w[0] && !wr |=> $stable(q.acc[0]))
      else $error("disabled counter moved");
   tmr_start_a: assert property (trig_rise0 |=>
      q.tst[0] == reflex_pkg::TMR_RUN && q.acc[0] == '0)
      else $error("edge timer did not start");
   tmr_hold_a: assert property (q.tst[0] == reflex_pkg::TMR_DONE &&
      !rise_w[0] && !fall_w[0] && !q.img_bits[2] && !wr
      |=> $stable(q.acc[0]))
      else $error("terminal count not held");
   bool_off_a: assert property (!en_w[1] |=> !q.out_ch[1])
      else $error("disabled block output high");
   lt_set_a: assert property (kind_w[1] == reflex_pkg::KIND_SCMP &&
      q.cfg[1][4:3] == reflex_pkg::CMP_LT && en_w[1] && !q.chain &&
      $signed(q.img_word) < $signed(q.thr1[1]) |=> q.cmp[1])
      else $error("less-than compare not set");

endmodule

// *** src/reflex_pkg.sv ***
// Purpose: Shared constants and types for the reflex function block bank.
// Assumes: 50 MHz pclk, APB register access, 32-bit data words.
// Notes: Two block slots sit in one output module; slot 0 may feed slot 1.
package reflex_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int MS_PER_S = 1000;
   localparam int HOLDOFF_MS = 10;
   localparam int MS_CYCLES_DFLT = CLK_HZ / MS_PER_S;
   localparam int HOLDOFF_CYCLES_DFLT = MS_CYCLES_DFLT * HOLDOFF_MS;
   localparam logic [9:0] UNIT_DIV_1 = 10'h001;
   localparam logic [9:0] UNIT_DIV_10 = 10'h00A;
   localparam logic [9:0] UNIT_DIV_100 = 10'h064;
   localparam logic [9:0] UNIT_DIV_1000 = 10'h3E8;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [2:0] SLOT_PAGE0 = 3'h1;
   localparam logic [2:0] SLOT_PAGE1 = 3'h2;
   localparam logic [4:0] OFS_CFG = 5'h00;
   localparam logic [4:0] OFS_THR1 = 5'h04;
   localparam logic [4:0] OFS_THR2 = 5'h08;
   localparam logic [4:0] OFS_DELTA = 5'h0C;
   localparam logic [4:0] OFS_PRESET = 5'h10;
   localparam logic [4:0] OFS_ACC = 5'h14;

   // ----------------------------------------
   // Field layout
   // ----------------------------------------
   localparam int CHAIN_BIT = 0;
   localparam int ALWAYS_EN_LSB = 1;
   localparam int KIND_LSB = 0;
   localparam int MODE_LSB = 3;
   localparam int INV_OUT_BIT = 5;
   localparam int INV_IN_LSB = 6;
   localparam int DOWN_BIT = 9;
   localparam int UNIT_LSB = 10;
   localparam int ST_USED_LSB = 2;
   localparam int ST_BUSY_BIT = 6;
   localparam int ST_CHAIN_BIT = 7;
   localparam int ISLAND_MAX_BLOCKS = 10;

   // ----------------------------------------
   // Encodings
   // ----------------------------------------
   localparam logic [2:0] KIND_OFF = 3'h0;
   localparam logic [2:0] KIND_BOOL = 3'h1;
   localparam logic [2:0] KIND_SCMP = 3'h2;
   localparam logic [2:0] KIND_UCMP = 3'h3;
   localparam logic [2:0] KIND_CNT = 3'h4;
   localparam logic [2:0] KIND_TMR = 3'h5;
   localparam logic [1:0] BOOL_XOR = 2'h0;
   localparam logic [1:0] BOOL_AND2 = 2'h1;
   localparam logic [1:0] BOOL_AND3 = 2'h2;
   localparam logic [1:0] CMP_LT = 2'h0;
   localparam logic [1:0] CMP_GT = 2'h1;
   localparam logic [1:0] CMP_IN = 2'h2;
   localparam logic [1:0] CMP_OUT = 2'h3;
   localparam logic [1:0] TMR_DSTART = 2'h0;
   localparam logic [1:0] TMR_DSTOP = 2'h1;
   localparam logic [1:0] TMR_RISE = 2'h2;
   localparam logic [1:0] TMR_FALL = 2'h3;

   typedef enum logic [2:0] {
      TMR_IDLE = 3'b001,
      TMR_RUN = 3'b010,
      TMR_DONE = 3'b100
   } tmr_state_t;

endpackage
